// ===== pkg/aocr_pkg.sv
// Constants, field layout and carrier types of the converter output configuration bank
package aocr_pkg;
  // Register addresses
  localparam logic [7:0] AOCR_ADDR_GENERAL       = 8'h00;
  localparam logic [7:0] AOCR_ADDR_PATTERN_A     = 8'h25;
  localparam logic [7:0] AOCR_ADDR_PATTERN_B     = 8'h2B;
  localparam logic [7:0] AOCR_ADDR_OFFSET_CTRL   = 8'h3D;
  localparam logic [7:0] AOCR_ADDR_FIXED_UPPER   = 8'h3F;
  localparam logic [7:0] AOCR_ADDR_FIXED_LOWER   = 8'h40;
  localparam logic [7:0] AOCR_ADDR_OUTPUT_IF     = 8'h41;
  localparam logic [7:0] AOCR_ADDR_CLOCK_POS     = 8'h42;
  // Reset value of every register in the bank
  localparam logic [7:0] AOCR_REG_RESET          = 8'h00;
  // Field positions
  localparam int AOCR_BIT_READOUT      = 0;
  localparam int AOCR_BIT_SWRESET      = 1;
  localparam int AOCR_BIT_OFFSET_ON    = 5;
  localparam int AOCR_BIT_DIGITAL_EN   = 3;
  localparam int AOCR_POS_IF_SEL       = 6;
  localparam int AOCR_POS_DRIVE        = 4;
  localparam int AOCR_POS_POWERDOWN    = 0;
  localparam int AOCR_POS_FALL_SHIFT   = 6;
  localparam int AOCR_POS_RISE_SHIFT   = 4;
  localparam int AOCR_POS_PAT_SEL      = 0;
  localparam int AOCR_UPPER_WIDTH      = 6;
  // Field codes
  localparam logic [1:0] AOCR_IF_CMOS       = 2'h3;
  localparam logic [1:0] AOCR_PD_CHAN_B     = 2'h1;
  localparam logic [1:0] AOCR_PD_CHAN_A     = 2'h2;
  localparam logic [1:0] AOCR_PD_ALL        = 2'h3;
  localparam logic [2:0] AOCR_PAT_FIXED     = 3'h5;
  // Serial frame: address byte then data byte, MSB first
  localparam logic [4:0] AOCR_ADDR_BITS     = 5'h08;
  localparam logic [4:0] AOCR_FRAME_BITS    = 5'h10;
  // Falling-edge shifts in picoseconds, negative means advance
  localparam logic signed [10:0] AOCR_LVDS_FALL_01 = -11'sd450;
  localparam logic signed [10:0] AOCR_LVDS_FALL_10 = -11'sd150;
  localparam logic signed [10:0] AOCR_LVDS_FALL_11 = 11'sd550;
  localparam logic signed [10:0] AOCR_CMOS_FALL_01 = 11'sd150;
  localparam logic signed [10:0] AOCR_CMOS_FALL_11 = -11'sd100;
  localparam logic signed [10:0] AOCR_FALL_NONE    = 11'sd0;

  // Decoded configuration carried to the output stage
  typedef struct packed {
    logic        offsetFixOn;
    logic [13:0] fixedWord;
    logic        cmosMode;
    logic [1:0]  cmosClockDriveLevel;
    logic [1:0]  outputBufferPowerdown;
    logic [1:0]  clockFallEdgeShift;
    logic [1:0]  clockRiseEdgeShift;
    logic        digitalEnable;
    logic        readoutEnable;
  } aocr_cfg_t;
endpackage : aocr_pkg

// ===== src/aocr_regs.sv
// Serial configuration port, register bank and output stage of the converter
`timescale 1ns/1ps
`default_nettype none

module aocr_regs
  import aocr_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 14
) (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic                           serialEnableN,
  input  wire logic                           serialClock,
  input  wire logic                           serialDataIn,
  output var  logic                           serialReadbackPin,
  output logic                                serialReadbackOe,
  input  wire logic [SAMPLE_WIDTH-1:0]        sampleA,
  input  wire logic [SAMPLE_WIDTH-1:0]        sampleB,
  output var  logic [SAMPLE_WIDTH-1:0]        dataA,
  output var  logic [SAMPLE_WIDTH-1:0]        dataB,
  output logic                                dataAOe,
  output logic                                dataBOe,
  output logic                                clockOutOe,
  output var  logic signed [10:0]             clockFallShiftPs,
  output aocr_cfg_t                           cfg
);

  // Synchroniser stages; stage one feeds only stage two
  logic [2:0] senSync;
  logic [2:0] sclkSync;
  logic [1:0] sdataSync;
  logic [15:0] shiftIn;
  logic [4:0]  bitCount;
  logic [7:0]  readShift;
  logic        commitWrite;
  logic        sclkRise;
  logic [7:0]  frameAddr;
  logic [7:0]  frameData;
  logic [7:0]  readValue;
  logic [2:0]  patSelA;
  logic [2:0]  patSelB;
  logic        patternOnA;
  logic        patternOnB;

  // Pins come from the host clock domain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      senSync   <= 3'h7;
      sclkSync  <= 3'h0;
      sdataSync <= 2'h0;
    end else begin
      senSync   <= {senSync[1:0], serialEnableN};
      sclkSync  <= {sclkSync[1:0], serialClock};
      sdataSync <= {sdataSync[0], serialDataIn};
    end
  end

  assign sclkRise    = sclkSync[1] & ~sclkSync[2];
  assign frameAddr   = shiftIn[15:8];
  assign frameData   = shiftIn[7:0];
  assign commitWrite = senSync[1] & ~senSync[2] & (bitCount == AOCR_FRAME_BITS);

  // Frame shifter; extra bits beyond a frame spoil the count so the frame is dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shiftIn  <= 16'h0000;
      bitCount <= 5'h00;
    end else if (senSync[1]) begin
      bitCount <= (commitWrite) ? bitCount : 5'h00;
    end else if (sclkRise) begin
      shiftIn  <= {shiftIn[14:0], sdataSync[1]};
      bitCount <= (bitCount == 5'h1F) ? bitCount : bitCount + 5'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg     <= '0;
      patSelA <= AOCR_REG_RESET[2:0];
      patSelB <= AOCR_REG_RESET[2:0];
    end else if (commitWrite) begin
      case (frameAddr)
        AOCR_ADDR_GENERAL: begin
          if (frameData[AOCR_BIT_SWRESET]) begin
            cfg     <= '0;
            patSelA <= AOCR_REG_RESET[2:0];
            patSelB <= AOCR_REG_RESET[2:0];
          end else begin
            cfg.readoutEnable <= frameData[AOCR_BIT_READOUT];
          end
        end
        AOCR_ADDR_PATTERN_A: patSelA <= frameData[AOCR_POS_PAT_SEL +: 3];
        AOCR_ADDR_PATTERN_B: patSelB <= frameData[AOCR_POS_PAT_SEL +: 3];
        AOCR_ADDR_OFFSET_CTRL: cfg.offsetFixOn <= frameData[AOCR_BIT_OFFSET_ON];
        AOCR_ADDR_FIXED_UPPER: cfg.fixedWord[13:8] <= frameData[AOCR_UPPER_WIDTH-1:0];
        AOCR_ADDR_FIXED_LOWER: cfg.fixedWord[7:0] <= frameData;
        AOCR_ADDR_OUTPUT_IF: begin
          cfg.cmosMode              <= (frameData[AOCR_POS_IF_SEL +: 2] == AOCR_IF_CMOS);
          cfg.cmosClockDriveLevel   <= frameData[AOCR_POS_DRIVE +: 2];
          cfg.outputBufferPowerdown <= frameData[AOCR_POS_POWERDOWN +: 2];
        end
        AOCR_ADDR_CLOCK_POS: begin
          cfg.clockFallEdgeShift <= frameData[AOCR_POS_FALL_SHIFT +: 2];
          cfg.clockRiseEdgeShift <= frameData[AOCR_POS_RISE_SHIFT +: 2];
          cfg.digitalEnable      <= frameData[AOCR_BIT_DIGITAL_EN];
        end
        default: ;
      endcase
    end
  end

  // Readback image; unassigned and unmapped bits read zero
  // Loaded after eight bits, so the address byte still sits in the low half of the shifter
  always_comb begin
    readValue = 8'h00;
    case (shiftIn[7:0])
      AOCR_ADDR_GENERAL:     readValue[AOCR_BIT_READOUT] = cfg.readoutEnable;
      AOCR_ADDR_PATTERN_A:   readValue[2:0] = patSelA;
      AOCR_ADDR_PATTERN_B:   readValue[2:0] = patSelB;
      AOCR_ADDR_OFFSET_CTRL: readValue[AOCR_BIT_OFFSET_ON] = cfg.offsetFixOn;
      AOCR_ADDR_FIXED_UPPER: readValue[AOCR_UPPER_WIDTH-1:0] = cfg.fixedWord[13:8];
      AOCR_ADDR_FIXED_LOWER: readValue = cfg.fixedWord[7:0];
      AOCR_ADDR_OUTPUT_IF:   readValue = {cfg.cmosMode ? AOCR_IF_CMOS : 2'h0, cfg.cmosClockDriveLevel,
                                          2'h0, cfg.outputBufferPowerdown};
      AOCR_ADDR_CLOCK_POS:   readValue = {cfg.clockFallEdgeShift, cfg.clockRiseEdgeShift,
                                          cfg.digitalEnable, 3'h0};
      default:               readValue = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readShift <= 8'h00;
    end else if (!senSync[1] && sclkRise) begin
      if (bitCount == AOCR_ADDR_BITS - 5'h01) begin
        readShift <= 8'h00;
      end else begin
        readShift <= {readShift[6:0], 1'b0};
      end
    end else if (!senSync[1] && bitCount == AOCR_ADDR_BITS && sclkSync[1] == sclkSync[2]
                 && readShift == 8'h00) begin
      readShift <= readValue;
    end
  end

  assign serialReadbackOe = cfg.readoutEnable;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serialReadbackPin <= 1'b0;
    end else begin
      serialReadbackPin <= cfg.readoutEnable & readShift[7];
    end
  end

  assign patternOnA = cfg.digitalEnable && (patSelA == AOCR_PAT_FIXED);
  assign patternOnB = cfg.digitalEnable && (patSelB == AOCR_PAT_FIXED);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataA <= '0;
      dataB <= '0;
    end else begin
      dataA <= patternOnA ? SAMPLE_WIDTH'(cfg.fixedWord) : sampleA;
      dataB <= patternOnB ? SAMPLE_WIDTH'(cfg.fixedWord) : sampleB;
    end
  end

  assign dataAOe    = !(cfg.outputBufferPowerdown == AOCR_PD_CHAN_A || cfg.outputBufferPowerdown == AOCR_PD_ALL);
  assign dataBOe    = !(cfg.outputBufferPowerdown == AOCR_PD_CHAN_B || cfg.outputBufferPowerdown == AOCR_PD_ALL);
  assign clockOutOe = (cfg.outputBufferPowerdown != AOCR_PD_ALL);

  // Fall shift in LVDS and CMOS modes; the forbidden CMOS code gives no shift
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clockFallShiftPs <= AOCR_FALL_NONE;
    end else begin
      case ({cfg.cmosMode, cfg.clockFallEdgeShift})
        3'h1:    clockFallShiftPs <= AOCR_LVDS_FALL_01;
        3'h2:    clockFallShiftPs <= AOCR_LVDS_FALL_10;
        3'h3:    clockFallShiftPs <= AOCR_LVDS_FALL_11;
        3'h5:    clockFallShiftPs <= AOCR_CMOS_FALL_01;
        3'h7:    clockFallShiftPs <= AOCR_CMOS_FALL_11;
        default: clockFallShiftPs <= AOCR_FALL_NONE;
      endcase
    end
  end

  // Checks next to the logic they guard
  sequence writeTo(logic [7:0] a);
    commitWrite && frameAddr == a;
  endsequence

  AST_OFFSET_BIT: assert property (@(posedge clock) disable iff (rst)
    writeTo(AOCR_ADDR_OFFSET_CTRL) |=> cfg.offsetFixOn == $past(frameData[AOCR_BIT_OFFSET_ON]))
    else $error("offset enable not taken from bit 5");
  AST_UPPER_WORD: assert property (@(posedge clock) disable iff (rst)
    writeTo(AOCR_ADDR_FIXED_UPPER) |=> cfg.fixedWord[13:8] == $past(frameData[5:0]))
    else $error("upper pattern bits wrong");
  AST_LOWER_WORD: assert property (@(posedge clock) disable iff (rst)
    writeTo(AOCR_ADDR_FIXED_LOWER) |=> cfg.fixedWord[7:0] == $past(frameData))
    else $error("lower pattern bits wrong");
  AST_PATTERN_OUT: assert property (@(posedge clock) disable iff (rst)
    patternOnA |=> dataA == $past(cfg.fixedWord))
    else $error("fixed word not on channel A");
  AST_CMOS_SELECT: assert property (@(posedge clock) disable iff (rst)
    writeTo(AOCR_ADDR_OUTPUT_IF) |=> cfg.cmosMode == ($past(frameData[7:6]) == 2'h3))
    else $error("interface select wrong");
  AST_DRIVE_LEVEL: assert property (@(posedge clock) disable iff (rst)
    writeTo(AOCR_ADDR_OUTPUT_IF) |=> cfg.cmosClockDriveLevel == $past(frameData[5:4]))
    else $error("drive level wrong");
  AST_PD_CHAN_B: assert property (@(posedge clock) disable iff (rst)
    cfg.outputBufferPowerdown == 2'h1 |-> !dataBOe && dataAOe && clockOutOe)
    else $error("channel B power-down wrong");
  AST_PD_ALL: assert property (@(posedge clock) disable iff (rst)
    cfg.outputBufferPowerdown == 2'h3 |-> !dataAOe && !dataBOe && !clockOutOe)
    else $error("full power-down leaves a buffer driving");
  AST_LVDS_FALL: assert property (@(posedge clock) disable iff (rst)
    !cfg.cmosMode && cfg.clockFallEdgeShift == 2'h1 |=> clockFallShiftPs == -11'sd450)
    else $error("LVDS fall shift wrong");
  AST_CMOS_FALL: assert property (@(posedge clock) disable iff (rst)
    cfg.cmosMode && cfg.clockFallEdgeShift == 2'h3 |=> clockFallShiftPs == -11'sd100)
    else $error("CMOS fall shift wrong");
  AST_DIGITAL_GATE: assert property (@(posedge clock) disable iff (rst)
    !cfg.digitalEnable |-> !patternOnA && !patternOnB ##1 dataA == $past(sampleA))
    else $error("digital functions active while disabled");
  AST_SOFT_RESET: assert property (@(posedge clock) disable iff (rst)
    commitWrite && frameAddr == AOCR_ADDR_GENERAL && frameData[AOCR_BIT_SWRESET]
    |=> cfg == '0 && patSelA == 3'h0 && patSelB == 3'h0)
    else $error("software reset left a field set");
  AST_READBACK_HIZ: assert property (@(posedge clock) disable iff (rst)
    !cfg.readoutEnable |-> !serialReadbackOe ##1 !serialReadbackPin)
    else $error("readback pin driven while disabled");
  AST_ATOMIC: assert property (@(posedge clock) disable iff (rst)
    !commitWrite |=> $stable(cfg))
    else $error("configuration changed outside a frame end");

endmodule : aocr_regs
`default_nettype wire

// ===== testbench/aocr_host_model.sv
// Host controller model that drives the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module aocr_host_model (
  input  wire logic clock,
  input  wire logic readbackPin,
  input  wire logic readbackOe,
  output var  logic serialEnableN,
  output var  logic serialClock,
  output var  logic serialDataIn
);
  // Idle frame state: enable high, serial clock stands still low
  initial begin
    serialEnableN = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end

  // Move just after a rising edge, n periods on
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // MSB-first frame, cut to its first nBits bits
  // Phases of five system clocks keep clear of the three-clock synchroniser
  task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int nBits,
                       output logic [7:0] readData);
    logic [15:0] word;
    word = {addr, data};
    readData = 8'h00;
    step(1);
    serialEnableN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      serialDataIn = word[15-i];
      step(5);
      // Undriven readback pin yields unknown so it never passes a compare
      if (i >= 8) readData[15-i] = readbackOe ? readbackPin : 1'bx;
      serialClock = 1'b1;
      step(5);
      serialClock = 1'b0;
    end
    step(5);
    serialEnableN = 1'b1;
    serialDataIn = ~serialDataIn;  // Released line shows no stale bit
    step(8);
  endtask : frame
endmodule : aocr_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking testbench of the output configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aocr_pkg::*;
  logic               clock, rst, senN, sclk, sdi, pin, pinOe, aOe, bOe, ckOe;
  logic [13:0]        sampleA, sampleB, dataA, dataB;
  logic signed [10:0] fallPs;
  aocr_cfg_t          cfg;
  logic [7:0]         rd;
  // Signed so that advances widen the same way as the shift output does
  logic signed [10:0] lvdsTab [4] = '{11'h000, 11'h63E, 11'h76A, 11'h226};
  logic signed [10:0] cmosTab [4] = '{11'h000, 11'h096, 11'h000, 11'h79C};
  logic [2:0]         oeTab [4] = '{3'h7, 3'h5, 3'h3, 3'h0};
  int                 bad_count = 0;
  int                 checks = 0;

  aocr_regs #(.SAMPLE_WIDTH(14)) u_dut (
    .clock(clock), .rst(rst), .serialEnableN(senN), .serialClock(sclk), .serialDataIn(sdi),
    .serialReadbackPin(pin), .serialReadbackOe(pinOe), .sampleA(sampleA), .sampleB(sampleB),
    .dataA(dataA), .dataB(dataB), .dataAOe(aOe), .dataBOe(bOe), .clockOutOe(ckOe),
    .clockFallShiftPs(fallPs), .cfg(cfg));
  aocr_host_model u_host (
    .clock(clock), .readbackPin(pin), .readbackOe(pinOe),
    .serialEnableN(senN), .serialClock(sclk), .serialDataIn(sdi));

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compare four-state values and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.frame(a, d, 16, rd);
  endtask : wr

  // Resending the held value keeps a read frame harmless
  task automatic rdReg(input logic [7:0] a, input logic [7:0] keep);
    u_host.frame(a, keep, 16, rd);
  endtask : rdReg

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond some thirty frames of 174 clocks
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    sampleA = 14'h1234;
    sampleB = 14'h0ABC;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(cfg, 32'h0);
    check({aOe, bOe, ckOe, pinOe}, 32'hE);
    $display("test reset done");
    // pattern and offset fields, reserved bits zero
    wr(8'h3D, 8'h20);
    check(cfg.offsetFixOn, 32'h1);
    wr(8'h3F, 8'h15);
    wr(8'h40, 8'hA5);
    check(cfg.fixedWord, 32'h15A5);
    $display("test fields done");
    // fixed word gated by digital enable
    wr(8'h25, 8'h05);
    check(dataA, 32'h1234);
    wr(8'h42, 8'h08);
    check(dataA, 32'h15A5);
    check(dataB, 32'h0ABC);
    $display("test pattern done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h41, {c[1:0], c[1:0], 4'h0});
      check(cfg.cmosMode, {31'h0, c == 3});
      check(cfg.cmosClockDriveLevel, c);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h41, {6'h00, c[1:0]});
      check({aOe, bOe, ckOe}, oeTab[c]);
    end
    $display("test interface done");
    // falling edge shifts in both modes
    wr(8'h41, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h42, {c[1:0], 6'h00});
      check(fallPs, lvdsTab[c]);
    end
    check(dataA, 32'h1234);
    wr(8'h41, 8'hC0);
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      wr(8'h42, {c[1:0], 6'h00});
      check(fallPs, cmosTab[c]);
    end
    $display("test shift done");
    // readback and a short frame dropped
    wr(8'h00, 8'h01);
    check(pinOe, 32'h1);
    wr(8'h42, 8'hF8);
    check(cfg.clockRiseEdgeShift, 32'h3);
    rdReg(8'h42, 8'hF8);
    check(rd, 32'hF8);
    rdReg(8'h41, 8'hC0);
    check(rd, 32'hC0);
    rdReg(8'h40, 8'hA5);
    check(rd, 32'hA5);
    rdReg(8'h3F, 8'h15);
    check(rd, 32'h15);
    u_host.frame(8'h40, 8'h00, 8, rd);
    rdReg(8'h40, 8'hA5);
    check(rd, 32'hA5);
    $display("test readback done");
    wr(8'h00, 8'h02);
    check(cfg, 32'h0);
    check({aOe, bOe, ckOe, pinOe}, 32'hE);
    wr(8'h42, 8'h08);
    check(dataA, 32'h1234);
    $display("test soft reset done");
    // CMOS full power-down, then a hardware reset in mid-run
    wr(8'h41, 8'hC3);
    check({aOe, bOe, ckOe}, 32'h0);
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(cfg, 32'h0);
    check({aOe, bOe, ckOe, pinOe}, 32'hE);
    $display("test hard reset done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
